// ### rtc_alarm_pkg.sv
// constants for the dual alarm register block and the second-length trimming
// assumes a single 250 MHz core clock domain; register port driven by the serial engine
`default_nettype none
package rtc_alarm_pkg;
   localparam logic [3:0] WEEKLY_MINUTE_OFS = 4'h8;
   localparam logic [3:0] WEEKLY_HOUR_OFS = 4'h9;
   localparam logic [3:0] WEEKLY_DAY_MASK_OFS = 4'hA;
   localparam logic [3:0] DAILY_MINUTE_OFS = 4'hB;
   localparam logic [3:0] DAILY_HOUR_OFS = 4'hC;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int MINUTE_W = 7;
   localparam int HOUR_W = 6;
   localparam int DAY_W = 7;
   localparam int WEEKDAY_W = 3;
   localparam int HOUR_AFTERNOON_BIT = 5;
   localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
   localparam logic [MINUTE_W-1:0] MINUTE_RESET = 7'h00;
   localparam logic [HOUR_W-1:0] HOUR_RESET = 6'h00;
   localparam logic [DAY_W-1:0] DAY_MASK_RESET = 7'h00;
   localparam logic [WEEKDAY_W-1:0] WEEKDAY_LAST = 3'h6;
   // second length in crystal pulses and the trim step applied on 20 s slots
   localparam int PULSE_W = 16;
   localparam logic [PULSE_W-1:0] NOMINAL_PULSES = 16'h8000;
   localparam logic [PULSE_W-1:0] PULSE_ZERO = 16'h0000;
   localparam logic [PULSE_W-1:0] PULSE_ONE = 16'h0001;
   localparam int TRIM_W = 7;
   localparam int TRIM_DIR_BIT = 6;
   localparam int TRIM_STEP_SHIFT = 1;
   localparam logic [5:0] TRIM_NEUTRAL_MAX = 6'h01;
   localparam logic [5:0] TRIM_ONE = 6'h01;
   localparam int TRIM_PERIOD_S = 20;
endpackage
`default_nettype wire

// ### alarm_match_if.sv
// carries one alarm's programmed time and the running time to a comparator
// assumes both ends sit on the core clock
`default_nettype none
interface alarm_match_if;
   import rtc_alarm_pkg::*;
   logic [MINUTE_W-1:0] alarm_minute;
   logic [HOUR_W-1:0] alarm_hour;
   logic [DAY_W-1:0] day_enable;
   logic use_day_mask;
   logic [MINUTE_W-1:0] cur_minute;
   logic [HOUR_W-1:0] cur_hour;
   logic [WEEKDAY_W-1:0] weekday;
   logic match;
   modport cmp (input alarm_minute, alarm_hour, day_enable, use_day_mask, cur_minute, cur_hour, weekday,
                output match);
   modport owner (output alarm_minute, alarm_hour, day_enable, use_day_mask, cur_minute, cur_hour, weekday,
                  input match);
endinterface
`default_nettype wire

// ### alarm_compare.sv
// one alarm comparator: registered match level against the running time
// assumes running time comes from same-clock counters, no synchroniser needed
`default_nettype none
module alarm_compare
   import rtc_alarm_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   alarm_match_if.cmp am
);
   typedef struct packed {
      logic match;
   } cmp_state_t;

   cmp_state_t state_reg;
   cmp_state_t state_next;
   logic day_ok;

   always_comb begin
      state_next = state_reg;
      // weekday code 7 has no mask bit, so it never enables a weekly alarm
      day_ok = !am.use_day_mask || ((am.weekday <= WEEKDAY_LAST) && am.day_enable[am.weekday]);
      if (i_ce) begin
         // raw bit compare keeps the afternoon bit meaning identical to the hour counter's
         state_next.match = day_ok && (am.alarm_minute == am.cur_minute)
            && (am.alarm_hour == am.cur_hour);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign am.match = state_reg.match;

   property p_empty_mask_silent;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && am.use_day_mask && am.day_enable == '0) |=> !am.match;
   endproperty
   a_empty_mask_silent: assert property (p_empty_mask_silent) else $error("alarm fired with empty day mask");

   property p_day_select;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && am.use_day_mask && am.weekday <= WEEKDAY_LAST && !am.day_enable[am.weekday]) |=> !am.match;
   endproperty
   a_day_select: assert property (p_day_select) else $error("alarm fired on a masked weekday");

   property p_match_follows_time;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && am.alarm_minute == am.cur_minute && am.alarm_hour == am.cur_hour && !am.use_day_mask)
         |=> am.match;
   endproperty
   a_match_follows_time: assert property (p_match_follows_time) else $error("equal time gave no match");

   property p_hour_mismatch;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && am.alarm_hour[HOUR_AFTERNOON_BIT] != am.cur_hour[HOUR_AFTERNOON_BIT]) |=> !am.match;
   endproperty
   a_hour_mismatch: assert property (p_hour_mismatch) else $error("afternoon bit ignored in compare");
endmodule
`default_nettype wire

// ### rtc_alarm_regs.sv
// weekly and daily alarm registers with comparators, plus the trimmed second prescaler
// assumes the serial engine drives the register port on the core clock;
// the crystal level arrives asynchronously and is synchronised here
`default_nettype none
module rtc_alarm_regs
   import rtc_alarm_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [DATA_W-1:0] i_reg_wdata,
   output logic [DATA_W-1:0] o_reg_rdata,
   input wire logic [MINUTE_W-1:0] i_cur_minute,
   input wire logic [HOUR_W-1:0] i_cur_hour,
   input wire logic [WEEKDAY_W-1:0] i_weekday,
   input wire logic [TRIM_W-1:0] i_trim,
   input wire logic i_trim_slot,
   input wire logic i_xtal_32k,
   output logic o_clk_32k_out,
   output logic o_sec_tick,
   output logic o_weekly_alarm_match,
   output logic o_daily_alarm_match
);
   typedef struct packed {
      logic [MINUTE_W-1:0] weekly_minute;
      logic [HOUR_W-1:0] weekly_hour;
      logic [DAY_W-1:0] weekly_day_mask;
      logic [MINUTE_W-1:0] daily_minute;
      logic [HOUR_W-1:0] daily_hour;
      logic [DATA_W-1:0] rdata;
      logic xtal_meta;
      logic xtal_sync;
      logic xtal_prev;
      logic clk_out;
      logic [PULSE_W-1:0] pulse_cnt;
      logic sec_tick;
   } regs_state_t;

   regs_state_t state_reg;
   regs_state_t state_next;
   logic [PULSE_W-1:0] second_len;
   logic [PULSE_W-1:0] trim_delta;
   logic xtal_rise;
   logic [TRIM_DIR_BIT-1:0] trim_mag;

   alarm_match_if weekly_if ();
   alarm_match_if daily_if ();

   assign trim_mag = i_trim[TRIM_DIR_BIT-1:0];

   // second length for the current second; only slot seconds are stretched or shortened
   always_comb begin
      trim_delta = PULSE_ZERO;
      if (i_trim[TRIM_DIR_BIT]) begin
         trim_delta = PULSE_W'({(~trim_mag) + TRIM_ONE, 1'b0});
      end else if (trim_mag > TRIM_NEUTRAL_MAX) begin
         trim_delta = PULSE_W'({trim_mag - TRIM_ONE, 1'b0});
      end
      second_len = NOMINAL_PULSES;
      if (i_trim_slot && trim_mag > TRIM_NEUTRAL_MAX) begin
         second_len = i_trim[TRIM_DIR_BIT] ? NOMINAL_PULSES - trim_delta : NOMINAL_PULSES + trim_delta;
      end
   end

   assign xtal_rise = state_reg.xtal_sync && !state_reg.xtal_prev;

   always_comb begin
      state_next = state_reg;
      if (i_ce) begin
         state_next.xtal_meta = i_xtal_32k;
         state_next.xtal_sync = state_reg.xtal_meta;
         state_next.xtal_prev = state_reg.xtal_sync;
         // output follows the crystal alone, so no trim setting can disturb it
         state_next.clk_out = state_reg.xtal_sync;
         state_next.sec_tick = 1'b0;
         if (xtal_rise) begin
            if (state_reg.pulse_cnt >= second_len - PULSE_ONE) begin
               state_next.pulse_cnt = PULSE_ZERO;
               state_next.sec_tick = 1'b1;
            end else begin
               state_next.pulse_cnt = state_reg.pulse_cnt + PULSE_ONE;
            end
         end
         if (i_reg_wr) begin
            unique case (i_reg_addr)
               WEEKLY_MINUTE_OFS: state_next.weekly_minute = i_reg_wdata[MINUTE_W-1:0];
               WEEKLY_HOUR_OFS: state_next.weekly_hour = i_reg_wdata[HOUR_W-1:0];
               WEEKLY_DAY_MASK_OFS: state_next.weekly_day_mask = i_reg_wdata[DAY_W-1:0];
               DAILY_MINUTE_OFS: state_next.daily_minute = i_reg_wdata[MINUTE_W-1:0];
               DAILY_HOUR_OFS: state_next.daily_hour = i_reg_wdata[HOUR_W-1:0];
               default: ;
            endcase
         end
         // unused upper bits are never stored, so they read zero
         unique case (i_reg_addr)
            WEEKLY_MINUTE_OFS: state_next.rdata = DATA_W'(state_reg.weekly_minute);
            WEEKLY_HOUR_OFS: state_next.rdata = DATA_W'(state_reg.weekly_hour);
            WEEKLY_DAY_MASK_OFS: state_next.rdata = DATA_W'(state_reg.weekly_day_mask);
            DAILY_MINUTE_OFS: state_next.rdata = DATA_W'(state_reg.daily_minute);
            DAILY_HOUR_OFS: state_next.rdata = DATA_W'(state_reg.daily_hour);
            default: state_next.rdata = READ_ZERO;
         endcase
      end
   end

   // alarm contents carry no meaning after an oscillation halt; reset only makes simulation defined
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign weekly_if.alarm_minute = state_reg.weekly_minute;
   assign weekly_if.alarm_hour = state_reg.weekly_hour;
   assign weekly_if.day_enable = state_reg.weekly_day_mask;
   assign weekly_if.use_day_mask = 1'b1;
   assign weekly_if.cur_minute = i_cur_minute;
   assign weekly_if.cur_hour = i_cur_hour;
   assign weekly_if.weekday = i_weekday;
   assign daily_if.alarm_minute = state_reg.daily_minute;
   assign daily_if.alarm_hour = state_reg.daily_hour;
   assign daily_if.day_enable = DAY_MASK_RESET;
   assign daily_if.use_day_mask = 1'b0;
   assign daily_if.cur_minute = i_cur_minute;
   assign daily_if.cur_hour = i_cur_hour;
   assign daily_if.weekday = i_weekday;

   alarm_compare u_weekly (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .am(weekly_if)
   );

   alarm_compare u_daily (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .am(daily_if)
   );

   assign o_reg_rdata = state_reg.rdata;
   assign o_clk_32k_out = state_reg.clk_out;
   assign o_sec_tick = state_reg.sec_tick;
   assign o_weekly_alarm_match = weekly_if.match;
   assign o_daily_alarm_match = daily_if.match;

   property p_weekly_minute_rd;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && !i_reg_wr && i_reg_addr == WEEKLY_MINUTE_OFS)
         |=> o_reg_rdata == {1'b0, $past(state_reg.weekly_minute)};
   endproperty
   a_weekly_minute_rd: assert property (p_weekly_minute_rd) else $error("weekly minute readback wrong");

   property p_weekly_hour_wr;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && i_reg_wr && i_reg_addr == WEEKLY_HOUR_OFS) ##1 (i_ce && !i_reg_wr && i_reg_addr == WEEKLY_HOUR_OFS)
         |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h3F);
   endproperty
   a_weekly_hour_wr: assert property (p_weekly_hour_wr) else $error("weekly hour write not read back");

   property p_mask_top_zero;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && i_reg_addr == WEEKLY_DAY_MASK_OFS) |=> !o_reg_rdata[7];
   endproperty
   a_mask_top_zero: assert property (p_mask_top_zero) else $error("day mask bit 7 read as one");

   property p_daily_minute_wr;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && i_reg_wr && i_reg_addr == DAILY_MINUTE_OFS) |=> state_reg.daily_minute == $past(i_reg_wdata[6:0]);
   endproperty
   a_daily_minute_wr: assert property (p_daily_minute_wr) else $error("daily minute not stored");

   property p_daily_hour_rd;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && i_reg_addr == DAILY_HOUR_OFS) |=> o_reg_rdata[7:6] == 2'b00;
   endproperty
   a_daily_hour_rd: assert property (p_daily_hour_rd) else $error("daily hour upper bits nonzero");

   property p_clk_out_free;
      @(posedge i_core_clk) disable iff (i_rst)
      i_ce |=> o_clk_32k_out == $past(state_reg.xtal_sync);
   endproperty
   a_clk_out_free: assert property (p_clk_out_free) else $error("clock output disturbed");

   property p_tick_at_length;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && xtal_rise && state_reg.pulse_cnt == second_len - PULSE_ONE)
         |=> (o_sec_tick && state_reg.pulse_cnt == '0);
   endproperty
   a_tick_at_length: assert property (p_tick_at_length) else $error("second did not end at its length");

   property p_no_early_tick;
      @(posedge i_core_clk) disable iff (i_rst)
      (i_ce && !(xtal_rise && state_reg.pulse_cnt >= second_len - PULSE_ONE)) |=> !o_sec_tick;
   endproperty
   a_no_early_tick: assert property (p_no_early_tick) else $error("second ended early");
endmodule
`default_nettype wire

// ### xtal_source.sv
// stand-in for the crystal feeding the block's asynchronous crystal input
// assumes the bench gates it; the level stays put while stopped, as a halted crystal would
`default_nettype none
module xtal_source #(
   parameter real HALF_NS = 7.3
) (
   input wire logic i_run,
   output logic o_xtal
);
   timeunit 1ns;
   timeprecision 1ps;
   // phase unrelated to the core clock so the synchroniser sees every alignment
   initial begin
      o_xtal = 1'b0;
      forever begin
         #(HALF_NS);
         if (i_run) begin
            o_xtal = ~o_xtal;
         end
      end
   end
endmodule
`default_nettype wire

// ### rtc_alarm_regs_tb.sv
// self-checking bench: register map, weekly and daily alarm matching, 32 kHz pass-through
// assumes the register port is driven straight on the core clock; the seconds tick is not
// reached, since one counted second would take about 120 thousand core cycles
`default_nettype none
module rtc_alarm_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_alarm_pkg::*;
   logic clk, rst, ce, wr, xtal, xrun, clk_out, sec_tick, wmatch, dmatch, trim_slot;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [MINUTE_W-1:0] cur_min;
   logic [HOUR_W-1:0] cur_hour;
   logic [WEEKDAY_W-1:0] weekday;
   logic [TRIM_W-1:0] trim;
   logic [7:0] shadow [0:15];
   logic [15:0] n_xtal, n_out;
   logic [31:0] r;
   int seed = 6536;
   int n_fail, checks, cycles, n_tick;

   rtc_alarm_regs uut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_addr(addr), .i_reg_wr(wr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_cur_minute(cur_min), .i_cur_hour(cur_hour),
      .i_weekday(weekday), .i_trim(trim), .i_trim_slot(trim_slot), .i_xtal_32k(xtal),
      .o_clk_32k_out(clk_out), .o_sec_tick(sec_tick), .o_weekly_alarm_match(wmatch),
      .o_daily_alarm_match(dmatch));
   xtal_source xtal_gen (.i_run(xrun), .o_xtal(xtal));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge xtal) n_xtal++;
   always @(posedge clk_out) n_out++;
   always @(negedge clk) if (sec_tick) n_tick++;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         report_and_stop();
      end
   end

   function automatic logic [7:0] reg_mask(input logic [3:0] a);
      case (a)
         WEEKLY_MINUTE_OFS, WEEKLY_DAY_MASK_OFS, DAILY_MINUTE_OFS: return 8'h7f;
         WEEKLY_HOUR_OFS, DAILY_HOUR_OFS: return 8'h3f;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] bcd(input int v);
      return 8'((v / 10) * 16 + v % 10);
   endfunction
   // weekday 7 lands on bit 7 of the shadow, which is always zero
   function automatic logic [7:0] exp_weekly();
      return {7'h00, cur_min == shadow[WEEKLY_MINUTE_OFS][6:0] && cur_hour == shadow[WEEKLY_HOUR_OFS][5:0]
         && shadow[WEEKLY_DAY_MASK_OFS][weekday]};
   endfunction
   function automatic logic [7:0] exp_daily();
      return {7'h00, cur_min == shadow[DAILY_MINUTE_OFS][6:0] && cur_hour == shadow[DAILY_HOUR_OFS][5:0]};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      shadow[a] = d & reg_mask(a);
      @(negedge clk);
   endtask
   task automatic rd_check(input logic [3:0] a);
      addr = a;
      @(negedge clk);
      check("rdata", rdata, shadow[a]);
   endtask
   task automatic match_check();
      repeat (2) @(negedge clk);
      check("weekly_match", {7'h00, wmatch}, exp_weekly());
      check("daily_match", {7'h00, dmatch}, exp_daily());
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      {rst, ce, wr, xrun, trim_slot} = 5'b11000;
      {addr, wdata, cur_min, cur_hour, weekday, trim} = '0;
      {n_xtal, n_out, n_fail, checks, cycles, n_tick} = '0;
      for (int i = 0; i < 16; i++) shadow[i] = 8'h00;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      xrun = 1'b1;
      // every address, unmapped ones too, with random bytes that always set bit 7, an always-zero bit
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 16; i++) wr_reg(4'(i), 8'($random(seed)) | 8'h80);
         for (int i = 0; i < 16; i++) rd_check(4'(i));
      end
      // 12-hour encoding: midnight 12h against noon 32h, bit 5 is the afternoon flag
      wr_reg(WEEKLY_MINUTE_OFS, 8'h00);
      wr_reg(DAILY_MINUTE_OFS, 8'h00);
      wr_reg(WEEKLY_DAY_MASK_OFS, 8'h7f);
      wr_reg(WEEKLY_HOUR_OFS, 8'h12);
      wr_reg(DAILY_HOUR_OFS, 8'h32);
      cur_min = 7'h00;
      for (int i = 0; i < 2; i++) begin
         cur_hour = i ? 6'h32 : 6'h12;
         weekday = 3'(i * 3);
         match_check();
      end
      // enable low: a write, a new time and the crystal are all held off; the crystal is
      // stopped too, so the frozen synchroniser cannot miss a pulse
      {ce, xrun, wr} = 3'b001;
      addr = DAILY_HOUR_OFS;
      wdata = 8'h12;
      cur_hour = 6'h12;
      weekday = 3'h0;
      repeat (3) @(negedge clk);
      check("frozen_weekly_match", {7'h00, wmatch}, 8'h00);
      check("frozen_daily_match", {7'h00, dmatch}, 8'h01);
      {ce, xrun, wr} = 3'b110;
      rd_check(DAILY_HOUR_OFS);
      match_check();
      for (int n = 0; n < 240; n++) begin
         if (n % 16 == 0) begin
            // host keeps to valid 24-hour times
            wr_reg(WEEKLY_MINUTE_OFS, bcd($unsigned($random(seed)) % 60));
            wr_reg(WEEKLY_HOUR_OFS, bcd($unsigned($random(seed)) % 24));
            wr_reg(WEEKLY_DAY_MASK_OFS, n < 32 ? 8'h00 : 8'($random(seed)));
            wr_reg(DAILY_MINUTE_OFS, bcd($unsigned($random(seed)) % 60));
            wr_reg(DAILY_HOUR_OFS, bcd($unsigned($random(seed)) % 24));
         end
         r = $random(seed);
         cur_min = r[0] ? shadow[WEEKLY_MINUTE_OFS][6:0] : (r[1] ? shadow[DAILY_MINUTE_OFS][6:0] :
            7'(bcd($unsigned($random(seed)) % 60)));
         cur_hour = r[2] ? shadow[WEEKLY_HOUR_OFS][5:0] : (r[3] ? shadow[DAILY_HOUR_OFS][5:0] :
            6'(bcd($unsigned($random(seed)) % 24)));
         weekday = r[6:4];
         trim = r[14:8];
         trim_slot = r[15];
         match_check();
      end
      // the crystal output follows every pulse whatever trim was applied meanwhile
      xrun = 1'b0;
      repeat (20) @(negedge clk);
      check("clk_32k_pulses_lo", n_out[7:0], n_xtal[7:0]);
      check("clk_32k_pulses_hi", n_out[15:8], n_xtal[15:8]);
      // even the shortest trimmed second needs far more pulses than this run makes
      check("sec_tick_count", n_tick[7:0], 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
